// ===== backlight_serial_port_and_protection.sv
// Notes on behaviour
// - Undervoltage select off or 2.7/5.4/8.1V; trip stops outputs, faults.
// - Undervoltage shutdown releases at or above threshold plus hysteresis.
// - Latched faults clear on enable low or fault register read.
// - Over-current shuts the device down until the fault clears.
// - Above limit, duty drops 2% of full scale per degree.
// - Regulation runs whenever the chip is enabled and a limit is selected.
// - Regulation sets no fault bit and leaves fault pin alone.
// - Temperature upper byte read snapshots lower byte for consistency.
// - Limit select off or 110/120/130 degrees for codes 1..3.
// - At 150 degrees outputs and boost stop, fault pin low.
// - Thermal shutdown ends once temperature falls below 130 degrees.
// - Slave only, address 2Ch, acknowledged when first seven bits match.
// - Sample with clock high; data change with clock high aborts.
// - Bytes are eight bits, MSB first, then an acknowledge slot.
// - Ninth clock: transmitter releases data, receiver pulls low.
// - Eighth bit after start: one transmits, zero receives.
// - Write: register address, data bytes, address steps after each.
// - Each master-acknowledged read byte advances to next register.
`timescale 1ns/1ns
`default_nettype none
module backlight_serial_port_and_protection #(
    parameter logic [7:0] ID_VALUE = 8'h5A // Arbitrary identity value
) (
    // Core clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Serial link
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Enable pin
    input wire logic en_pin,
    // Sensing and configuration
    input wire backlight_pkg::sense_type sense,
    input wire backlight_pkg::config_type cfg,
    // Power stage control
    output logic led_enable,
    output logic boost_enable,
    output logic [7:0] led_duty,
    output logic [3:0] direct_outputs,
    // Open-drain fault pin
    output logic fault_out,
    output logic fault_oe
);
    // Link domain: data bit caught at each clock rise
    logic link_bit;
    logic link_toggle;

    // Core domain synchronisers and edges
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [1:0] en_sync;
    logic [1:0] tog_sync;
    logic scl_prev;
    logic sda_prev;
    logic tog_prev;

    // Serial engine state
    backlight_pkg::serial_state_type state;
    logic [3:0] bit_cnt;
    logic [7:0] shift_in;
    logic [7:0] tx_byte;
    logic [7:0] reg_ptr;
    logic ack_pend;
    logic read_dir;
    logic after_ack;
    logic master_ack;

    // Registers and protection state
    logic [7:0] brightness;
    logic [7:0] dev_ctl;
    logic [3:0] direct_ctl;
    logic [7:0] faults;
    logic [2:0] temp_lsb_snap;
    logic uv_active;
    logic tsd_active;

    // Combinational decode
    logic bit_evt;
    logic fall_evt;
    logic start_evt;
    logic stop_evt;
    logic [7:0] byte_in;
    logic [7:0] temp_deg;
    logic [7:0] limit;
    logic [8:0] uv_thr;
    logic fault_read;
    logic uv_set;
    logic tsd_set;
    logic running;
    logic derating;
    logic [17:0] cut;
    logic [7:0] next_duty;
    logic [7:0] cur_value;
    logic [7:0] inc_value;

    // Sample data on each rising link clock
    always_ff @(posedge scl or negedge rst_b) begin
        if (!rst_b) begin
            link_bit <= 1'b1;
            link_toggle <= 1'b0;
        end else begin
            link_bit <= sda_in;
            link_toggle <= ~link_toggle;
        end
    end

    // Two-stage synchronisers for pins and toggle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            en_sync <= 2'h0;
            tog_sync <= 2'h0;
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
            tog_prev <= 1'b0;
        end else begin
            scl_sync <= {scl_sync[0], scl};
            sda_sync <= {sda_sync[0], sda_in};
            en_sync <= {en_sync[0], en_pin};
            tog_sync <= {tog_sync[0], link_toggle};
            scl_prev <= scl_sync[1];
            sda_prev <= sda_sync[1];
            tog_prev <= tog_sync[1];
        end
    end

    // Edge and condition decode
    always_comb begin
        bit_evt = tog_sync[1] ^ tog_prev;
        fall_evt = scl_prev & ~scl_sync[1];
        start_evt = scl_prev & scl_sync[1] & sda_prev & ~sda_sync[1];
        stop_evt = scl_prev & scl_sync[1] & ~sda_prev & sda_sync[1];
        byte_in = {shift_in[6:0], link_bit};
        // Byte to load now, and after a pointer step
        cur_value = reg_value(reg_ptr);
        inc_value = reg_value(reg_ptr + 8'h01);
    end

    // Serial engine
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= backlight_pkg::ST_IDLE;
            bit_cnt <= 4'h0;
            shift_in <= 8'h00;
            tx_byte <= 8'h00;
            reg_ptr <= 8'h00;
            ack_pend <= 1'b0;
            read_dir <= 1'b0;
            after_ack <= 1'b0;
            master_ack <= 1'b0;
            sda_oe <= 1'b0;
        end else if (start_evt) begin
            // start mid-byte aborts, new address phase
            state <= backlight_pkg::ST_ADDR;
            bit_cnt <= 4'h0;
            ack_pend <= 1'b0;
            after_ack <= 1'b0;
            sda_oe <= 1'b0;
        end else if (stop_evt) begin
            state <= backlight_pkg::ST_IDLE;
            bit_cnt <= 4'h0;
            ack_pend <= 1'b0;
            after_ack <= 1'b0;
            sda_oe <= 1'b0;
        end else if (bit_evt && state != backlight_pkg::ST_IDLE &&
                     state != backlight_pkg::ST_IGNORE) begin
            if (bit_cnt == backlight_pkg::ACK_SLOT) begin
                // master ack sampled on ninth clock
                master_ack <= ~link_bit;
                bit_cnt <= 4'h0;
                after_ack <= 1'b1;
            end else begin
                shift_in <= byte_in;
                bit_cnt <= bit_cnt + 4'h1;
                after_ack <= 1'b0;
                if (bit_cnt == 4'h7) begin
                    case (state)
                        backlight_pkg::ST_ADDR: begin
                            if (byte_in[7:1] == backlight_pkg::SLAVE_ADDR) begin
                                ack_pend <= 1'b1;
                                read_dir <= byte_in[0];
                            end else begin
                                state <= backlight_pkg::ST_IGNORE;
                            end
                        end
                        backlight_pkg::ST_REG: begin
                            reg_ptr <= byte_in;
                            ack_pend <= 1'b1;
                        end
                        backlight_pkg::ST_WRITE: ack_pend <= 1'b1;
                        default: ack_pend <= 1'b0;
                    endcase
                end
            end
        end else if (fall_evt && state != backlight_pkg::ST_IDLE &&
                     state != backlight_pkg::ST_IGNORE) begin
            if (bit_cnt == backlight_pkg::ACK_SLOT) begin
                // pull low in ack slot, else release
                sda_oe <= ack_pend;
            end else if (bit_cnt == 4'h0 && after_ack) begin
                after_ack <= 1'b0;
                ack_pend <= 1'b0;
                case (state)
                    backlight_pkg::ST_ADDR: begin
                        if (read_dir) begin
                            state <= backlight_pkg::ST_READ;
                            tx_byte <= cur_value;
                            sda_oe <= ~cur_value[7];
                        end else begin
                            state <= backlight_pkg::ST_REG;
                            sda_oe <= 1'b0;
                        end
                    end
                    backlight_pkg::ST_REG: begin
                        state <= backlight_pkg::ST_WRITE;
                        sda_oe <= 1'b0;
                    end
                    backlight_pkg::ST_WRITE: begin
                        // step address after each data byte
                        reg_ptr <= reg_ptr + 8'h01;
                        sda_oe <= 1'b0;
                    end
                    default: begin
                        if (master_ack) begin
                            reg_ptr <= reg_ptr + 8'h01;
                            tx_byte <= inc_value;
                            sda_oe <= ~inc_value[7];
                        end else begin
                            state <= backlight_pkg::ST_IGNORE;
                            sda_oe <= 1'b0;
                        end
                    end
                endcase
            end else if (state == backlight_pkg::ST_READ) begin
                sda_oe <= ~tx_byte[3'h7 - bit_cnt[2:0]];
            end else begin
                sda_oe <= 1'b0;
            end
        end
    end

    // Read data for one register offset
    function automatic logic [7:0] reg_value(input logic [7:0] ptr);
        if (ptr == backlight_pkg::REG_BRIGHT) begin
            reg_value = brightness;
        end else if (ptr == backlight_pkg::REG_DEVCTL) begin
            reg_value = dev_ctl;
        end else if (ptr == backlight_pkg::REG_FAULT) begin
            reg_value = faults;
        end else if (ptr == backlight_pkg::REG_ID) begin
            reg_value = ID_VALUE;
        end else if (ptr == backlight_pkg::REG_DIRECT) begin
            reg_value = {4'h0, direct_ctl};
        end else if (ptr == backlight_pkg::REG_TEMP_MSB) begin
            reg_value = sense.temp_code[10:3];
        end else if (ptr == backlight_pkg::REG_TEMP_LSB) begin
            reg_value = {temp_lsb_snap, 5'h00};
        end else begin
            reg_value = 8'h00;
        end
    endfunction : reg_value

    // Register writes on completed data byte
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            brightness <= backlight_pkg::RESET_VALUE;
            dev_ctl <= backlight_pkg::RESET_VALUE;
            direct_ctl <= 4'h0;
        end else if (bit_evt && state == backlight_pkg::ST_WRITE &&
                     bit_cnt == 4'h7 && !start_evt && !stop_evt) begin
            if (reg_ptr == backlight_pkg::REG_BRIGHT) begin
                brightness <= byte_in;
            end else if (reg_ptr == backlight_pkg::REG_DEVCTL) begin
                dev_ctl <= {5'h00, byte_in[2:0]};
            end else if (reg_ptr == backlight_pkg::REG_DIRECT) begin
                direct_ctl <= byte_in[3:0];
            end
        end
    end

    // Protection decode
    always_comb begin
        temp_deg = sense.temp_code[10:3];
        limit = backlight_pkg::temp_limit(cfg.overtemp_limit_sel);
        uv_thr = backlight_pkg::uv_threshold(cfg.undervoltage_threshold_sel);
        // fault register loaded for transmission counts as read
        fault_read = fall_evt && after_ack && bit_cnt == 4'h0 &&
            !start_evt && !stop_evt && (
            (state == backlight_pkg::ST_ADDR && read_dir && ack_pend &&
             reg_ptr == backlight_pkg::REG_FAULT) ||
            (state == backlight_pkg::ST_READ && master_ack &&
             reg_ptr + 8'h01 == backlight_pkg::REG_FAULT));
        uv_set = uv_thr != 9'h000 && sense.vin_dv < uv_thr;
        tsd_set = temp_deg >= backlight_pkg::TSD_ON;
        // over-current latch holds off the device
        running = en_sync[1] && !uv_active && !tsd_active &&
            !faults[backlight_pkg::FAULT_OCP];
        // regulation whenever enabled and limit set
        derating = en_sync[1] && limit != 8'h00 && temp_deg > limit;
        // two percent of full scale per degree
        cut = 18'(temp_deg - limit) * backlight_pkg::FULL_SCALE *
            backlight_pkg::DERATE_PCT / backlight_pkg::PERCENT;
        if (!derating) begin
            next_duty = brightness;
        end else if (cut >= 18'(brightness)) begin
            next_duty = 8'h00;
        end else begin
            next_duty = brightness - cut[7:0];
        end
    end

    // Undervoltage and thermal shutdown states
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            uv_active <= 1'b0;
            tsd_active <= 1'b0;
        end else begin
            if (uv_set) begin
                uv_active <= 1'b1;
            end else if (sense.vin_dv >= uv_thr + backlight_pkg::UV_HYST) begin
                uv_active <= 1'b0;
            end
            if (tsd_set) begin
                tsd_active <= 1'b1;
            end else if (temp_deg < backlight_pkg::TSD_OFF) begin
                tsd_active <= 1'b0;
            end
        end
    end

    // Sticky fault bits, set beats clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            faults <= backlight_pkg::RESET_VALUE;
        end else begin
            // clear on enable low or read
            if (!en_sync[1] || fault_read) begin
                faults <= backlight_pkg::RESET_VALUE;
            end
            if (uv_set) begin
                faults[backlight_pkg::FAULT_UV] <= 1'b1;
            end
            if (tsd_set) begin
                faults[backlight_pkg::FAULT_TSD] <= 1'b1;
            end
            if (sense.overcurrent) begin
                faults[backlight_pkg::FAULT_OCP] <= 1'b1;
            end
        end
    end

    // Lower temperature bits caught on upper byte load
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            temp_lsb_snap <= 3'h0;
        end else if (fall_evt && after_ack && bit_cnt == 4'h0 && (
            (state == backlight_pkg::ST_ADDR && read_dir && ack_pend &&
             reg_ptr == backlight_pkg::REG_TEMP_MSB) ||
            (state == backlight_pkg::ST_READ && master_ack &&
             reg_ptr + 8'h01 == backlight_pkg::REG_TEMP_MSB))) begin
            temp_lsb_snap <= sense.temp_code[2:0];
        end
    end

    // Output stage
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            led_enable <= 1'b0;
            boost_enable <= 1'b0;
            led_duty <= 8'h00;
            direct_outputs <= 4'h0;
            fault_oe <= 1'b0;
            fault_out <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            led_enable <= running && dev_ctl[backlight_pkg::BL_CTL];
            boost_enable <= running && dev_ctl[backlight_pkg::BL_CTL];
            led_duty <= next_duty;
            direct_outputs <= direct_ctl;
            fault_oe <= faults != 8'h00;
            fault_out <= 1'b0;
            sda_out <= 1'b0;
        end
    end

    // Checks
    property p_uv_fault;
        @(posedge clk) disable iff (!rst_b)
        uv_set |=> faults[backlight_pkg::FAULT_UV] ##1 fault_oe;
    endproperty
    a_uv_fault: assert property (p_uv_fault)
        else $error("undervoltage did not latch fault");

    property p_uv_hold;
        @(posedge clk) disable iff (!rst_b)
        uv_active |=> !led_enable && !boost_enable;
    endproperty
    a_uv_hold: assert property (p_uv_hold)
        else $error("outputs on during undervoltage");

    property p_ocp_off;
        @(posedge clk) disable iff (!rst_b)
        faults[backlight_pkg::FAULT_OCP] && en_sync[1] && !fault_read
            |=> faults[backlight_pkg::FAULT_OCP] ##1 !boost_enable;
    endproperty
    a_ocp_off: assert property (p_ocp_off)
        else $error("boost running with over-current latched");

    property p_clear_en;
        @(posedge clk) disable iff (!rst_b)
        !en_sync[1] && !uv_set && !tsd_set && !sense.overcurrent
            |=> faults == 8'h00 ##1 !fault_oe;
    endproperty
    a_clear_en: assert property (p_clear_en)
        else $error("fault not cleared by enable low");

    property p_tsd;
        @(posedge clk) disable iff (!rst_b)
        tsd_set |=> tsd_active ##1 (!led_enable && fault_oe);
    endproperty
    a_tsd: assert property (p_tsd)
        else $error("thermal shutdown not applied");

    property p_tsd_release;
        @(posedge clk) disable iff (!rst_b)
        tsd_active && temp_deg >= backlight_pkg::TSD_OFF |=> tsd_active;
    endproperty
    a_tsd_release: assert property (p_tsd_release)
        else $error("thermal shutdown released too early");

    property p_derate;
        @(posedge clk) disable iff (!rst_b)
        derating && brightness != 8'h00 |=> led_duty < $past(brightness);
    endproperty
    a_derate: assert property (p_derate)
        else $error("duty not reduced above limit");

    property p_ignore;
        @(posedge clk) disable iff (!rst_b)
        state == backlight_pkg::ST_IGNORE |=> !sda_oe;
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("data line driven for other address");

    property p_ack;
        @(posedge clk) disable iff (!rst_b)
        fall_evt && bit_cnt == backlight_pkg::ACK_SLOT && ack_pend &&
            !start_evt && !stop_evt && state != backlight_pkg::ST_IDLE
            |=> sda_oe;
    endproperty
    a_ack: assert property (p_ack)
        else $error("acknowledge not driven");

    c_write: cover property (@(posedge clk) disable iff (!rst_b)
        state == backlight_pkg::ST_WRITE ##1 stop_evt);
    c_read: cover property (@(posedge clk) disable iff (!rst_b)
        state == backlight_pkg::ST_READ && fault_read);
    c_derate: cover property (@(posedge clk) disable iff (!rst_b)
        derating && led_enable);
endmodule : backlight_serial_port_and_protection
`default_nettype wire

// ===== backlight_pkg.sv
`default_nettype none
package backlight_pkg;
    // Slave address and register offsets
    localparam logic [6:0] SLAVE_ADDR = 7'h2C;
    localparam logic [7:0] REG_BRIGHT = 8'h00;
    localparam logic [7:0] REG_DEVCTL = 8'h01;
    localparam logic [7:0] REG_FAULT = 8'h02;
    localparam logic [7:0] REG_ID = 8'h03;
    localparam logic [7:0] REG_DIRECT = 8'h04;
    localparam logic [7:0] REG_TEMP_MSB = 8'h05;
    localparam logic [7:0] REG_TEMP_LSB = 8'h06;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    // Field positions
    localparam int FAULT_UV = 0;
    localparam int FAULT_TSD = 1;
    localparam int FAULT_OCP = 2;
    localparam int BL_CTL = 0;
    // Bit slot counts inside one byte
    localparam logic [3:0] ACK_SLOT = 4'h8;
    // Input voltage thresholds in tenths of a volt
    localparam logic [8:0] UV_THR_LOW = 9'h01B;
    localparam logic [8:0] UV_THR_MID = 9'h036;
    localparam logic [8:0] UV_THR_HIGH = 9'h051;
    localparam logic [8:0] UV_HYST = 9'h002;
    // Temperatures in whole degrees Celsius
    localparam logic [7:0] TLIM_LOW = 8'h6E;
    localparam logic [7:0] TLIM_MID = 8'h78;
    localparam logic [7:0] TLIM_HIGH = 8'h82;
    localparam logic [7:0] TSD_ON = 8'h96;
    localparam logic [7:0] TSD_OFF = 8'h82;
    // Derating: percent of full scale per degree
    localparam logic [17:0] DERATE_PCT = 18'h00002;
    localparam logic [17:0] FULL_SCALE = 18'h000FF;
    localparam logic [17:0] PERCENT = 18'h00064;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_REG, ST_WRITE, ST_READ, ST_IGNORE
    } serial_state_type;

    typedef struct packed {
        logic [8:0] vin_dv;
        logic [10:0] temp_code;
        logic overcurrent;
    } sense_type;

    typedef struct packed {
        logic [1:0] undervoltage_threshold_sel;
        logic [1:0] overtemp_limit_sel;
    } config_type;

    // Undervoltage threshold for a select code, zero when off
    function automatic logic [8:0] uv_threshold(input logic [1:0] sel);
        case (sel)
            2'h1: uv_threshold = UV_THR_LOW;
            2'h2: uv_threshold = UV_THR_MID;
            2'h3: uv_threshold = UV_THR_HIGH;
            default: uv_threshold = 9'h000;
        endcase
    endfunction : uv_threshold

    // Regulation limit for a select code, zero when off
    function automatic logic [7:0] temp_limit(input logic [1:0] sel);
        case (sel)
            2'h1: temp_limit = TLIM_LOW;
            2'h2: temp_limit = TLIM_MID;
            2'h3: temp_limit = TLIM_HIGH;
            default: temp_limit = 8'h00;
        endcase
    endfunction : temp_limit
endpackage : backlight_pkg
`default_nettype wire

// ===== i2c_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module i2c_host_model (
    // Link timebase and resolved line
    input wire logic lclk,
    input wire logic sda,
    // Driven pins
    output logic scl,
    output logic sda_pull
);
    // Idle: clock high, data released
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic ph();
        repeat (6) @(posedge lclk);
    endtask : ph
    task automatic start();
        @(posedge lclk);
        sda_pull = 1'b0;
        ph();
        scl = 1'b1;
        ph();
        sda_pull = 1'b1;
        ph();
        scl = 1'b0;
    endtask : start
    task automatic stop();
        @(posedge lclk);
        sda_pull = 1'b1;
        ph();
        scl = 1'b1;
        ph();
        sda_pull = 1'b0;
        ph();
    endtask : stop
    task automatic bit_x(input logic b, output logic s);
        @(posedge lclk);
        sda_pull = !b;
        ph();
        scl = 1'b1;
        ph();
        s = sda;
        scl = 1'b0;
    endtask : bit_x
    task automatic send(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_x(d[i], s);
        bit_x(1'b1, s);
        ack = !s;
    endtask : send
    // ack or nack on last byte
    task automatic recv(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, s);
            d[i] = s;
        end
        bit_x(!ack, s);
    endtask : recv
endmodule : i2c_host_model
`default_nettype wire

// ===== backlight_serial_port_and_protection_tb.sv
`timescale 1ns/1ns
`default_nettype none
module backlight_serial_port_and_protection_tb;
    logic clk = 1'b0;
    logic lclk = 1'b0;
    logic rst_b = 1'b0;
    logic en_pin = 1'b1;
    logic scl, sda_pull, sda_oe, sda_out, led_enable, boost_enable;
    logic fault_oe, fault_out, a;
    logic [7:0] led_duty, q[$];
    logic [3:0] direct_outputs;
    logic [7:0] exp_d [4] = '{8'hC8, 8'h7C, 8'hAF, 8'hC8};
    backlight_pkg::sense_type sense = '{9'h064, 11'h0C8, 1'b0};
    backlight_pkg::config_type cfg = '{2'h1, 2'h1};
    int fails = 0;
    int check_count = 0;
    // Pulled-up data line
    wire logic sda = !(sda_oe | sda_pull);
    always #5 clk = ~clk;
    always begin
        #3 lclk = ~lclk;
        #3;
    end
    backlight_serial_port_and_protection DUT (.clk(clk), .rst_b(rst_b),
        .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .en_pin(en_pin), .sense(sense), .cfg(cfg),
        .led_enable(led_enable), .boost_enable(boost_enable),
        .led_duty(led_duty), .direct_outputs(direct_outputs),
        .fault_out(fault_out), .fault_oe(fault_oe));
    i2c_host_model host (.lclk(lclk), .sda(sda), .scl(scl),
        .sda_pull(sda_pull));
    task automatic chk(input string n, input logic [7:0] e, g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic settle();
        repeat (8) @(negedge clk);
    endtask : settle
    task automatic wr(input logic [7:0] r, input logic [7:0] d [$]);
        host.start();
        host.send({backlight_pkg::SLAVE_ADDR, 1'b0}, a);
        chk("ack_a", 8'h01, 8'(a));
        host.send(r, a);
        foreach (d[i]) host.send(d[i], a);
        chk("ack_d", 8'h01, 8'(a));
        host.stop();
        settle();
    endtask : wr
    task automatic rd(input logic [7:0] r, input int n);
        logic [7:0] d;
        host.start();
        host.send({backlight_pkg::SLAVE_ADDR, 1'b0}, a);
        host.send(r, a);
        host.start();
        host.send({backlight_pkg::SLAVE_ADDR, 1'b1}, a);
        chk("ack_r", 8'h01, 8'(a));
        q = {};
        for (int i = 1; i <= n; i++) begin
            host.recv(i < n, d);
            q.push_back(d);
        end
        host.stop();
        settle();
    endtask : rd
    task automatic t_regs();
        wr(8'h00, '{8'hC8, 8'h01, 8'h00, 8'h00, 8'h05});
        chk("duty", 8'hC8, led_duty);
        chk("en", 8'h01, 8'(led_enable));
        chk("dir", 8'h05, 8'(direct_outputs));
        rd(8'h00, 5);
        chk("r0", 8'hC8, q[0]);
        chk("r1", 8'h01, q[1]);
        chk("r4", 8'h05, q[4]);
        host.start();
        host.send(8'h5A, a);
        host.stop();
        chk("nack", 8'h00, 8'(a));
        // Start in mid data byte drops that byte
        host.start();
        host.send({backlight_pkg::SLAVE_ADDR, 1'b0}, a);
        host.send(8'h00, a);
        for (int i = 0; i < 4; i++) host.bit_x(1'b0, a);
        host.start();
        host.stop();
        settle();
        chk("abort", 8'hC8, led_duty);
        chk("sda_od", 8'h00, 8'(sda_out));
    endtask : t_regs
    task automatic t_uv();
        sense.vin_dv = 9'h01A;
        settle();
        chk("uv_en", 8'h00, 8'(led_enable));
        chk("uv_pin", 8'h01, 8'(fault_oe));
        chk("uv_od", 8'h00, 8'(fault_out));
        sense.vin_dv = 9'h01D;
        settle();
        chk("uv_up", 8'h01, 8'(led_enable));
        rd(8'h02, 1);
        chk("uv_bit", 8'h01, q[0]);
        chk("uv_clr", 8'h00, 8'(fault_oe));
        // Other threshold codes: off, middle, high
        cfg.undervoltage_threshold_sel = 2'h0;
        sense.vin_dv = 9'h01A;
        settle();
        chk("uv_off", 8'h01, 8'(led_enable));
        cfg.undervoltage_threshold_sel = 2'h2;
        sense.vin_dv = 9'h050;
        settle();
        chk("uv_mid", 8'h01, 8'(led_enable));
        cfg.undervoltage_threshold_sel = 2'h3;
        settle();
        chk("uv_high", 8'h00, 8'(led_enable));
        sense.vin_dv = 9'h064;
        cfg.undervoltage_threshold_sel = 2'h1;
        rd(8'h02, 1);
        chk("uv_bit3", 8'h01, q[0]);
        chk("uv_back", 8'h01, 8'(led_enable));
    endtask : t_uv
    task automatic t_temp();
        sense.temp_code = {8'h7D, 3'h0};
        foreach (exp_d[i]) begin
            cfg.overtemp_limit_sel = 2'(i);
            settle();
            chk("lim", exp_d[i], led_duty);
        end
        cfg.overtemp_limit_sel = 2'h1;
        sense.temp_code = {8'h70, 3'h5};
        settle();
        chk("derate", 8'hBE, led_duty);
        chk("reg_pin", 8'h00, 8'(fault_oe));
        rd(8'h05, 2);
        chk("t_hi", 8'h70, q[0]);
        chk("t_lo", 8'hA0, q[1]);
        sense.temp_code = {8'h96, 3'h0};
        settle();
        chk("tsd", 8'h00, 8'(boost_enable));
        chk("tsd_pin", 8'h01, 8'(fault_oe));
        sense.temp_code = {8'h81, 3'h0};
        settle();
        chk("tsd_off", 8'h01, 8'(led_enable));
        en_pin = 1'b0;
        settle();
        chk("en_clr", 8'h00, 8'(fault_oe));
        en_pin = 1'b1;
        sense.temp_code = {8'h19, 3'h0};
        settle();
    endtask : t_temp
    task automatic t_ocp();
        sense.overcurrent = 1'b1;
        @(negedge clk);
        sense.overcurrent = 1'b0;
        settle();
        chk("ocp", 8'h00, 8'(led_enable));
        rd(8'h02, 1);
        chk("ocp_bit", 8'h04, q[0]);
        chk("ocp_rel", 8'h01, 8'(led_enable));
    endtask : t_ocp
    task automatic close_out();
        if (fails == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out
    // Watchdog
    initial begin
        #400000;
        fails++;
        close_out();
    end
    initial begin
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        settle();
        t_regs();
        t_uv();
        t_temp();
        t_ocp();
        close_out();
    end
endmodule : backlight_serial_port_and_protection_tb
`default_nettype wire
